// file: core/pt_top.v
// pulse-train positioning core: pulse engine, encoder compare, registers
// assumes a single-cycle register port and asynchronous pin inputs
`default_nettype none
`include "pt_defs.vh"
// Function
// - single speed: run on at start, off at 5000
// - two speed: fast off at 4500, run off at 5000
// - count main or cassette encoder pulses
// - two-pulse: forward and reverse lines
// - pulse/direction, direction low forward
// - pulse/direction, direction high forward
// - trapezoid ramp from initial to maximum speed
// - jog while condition holds, optional target stop
// - automatic home return
// - table mode runs stored entries
// - interpolation needs two cassettes
// - 32-bit count in two 16-bit words
// - about 300 us direction-to-pulse wait
// - home return pulses until home input
// - own pulses count up forward, down reverse
module pt_top #(
  parameter [31:0] DIR_WAIT_CYC = `PT_DIR_WAIT_US * `PT_CLK_MHZ
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // register port
  input  wire [5:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  // pins in
  input  wire        encoder_in_main_i,
  input  wire        encoder_in_cassette_i,
  input  wire        start_in_main_i,
  input  wire        start_in_cassette_i,
  input  wire        home_i,
  input  wire        two_cassettes_i,
  // inverter outputs
  output reg         inverter_run_out_main_o,
  output reg         inverter_fast_out_main_o,
  output reg         inverter_run_out_cassette_o,
  output reg         inverter_fast_out_cassette_o,
  // pulse outputs
  output reg         pls_a_o,
  output reg         pls_b_o,
  output reg         pls2_a_o,
  output reg         pls2_b_o,
  // flags
  output reg         counter_ch0_busy_flag_o,
  output reg         counter_ch8_busy_flag_o,
  output reg         pulse_busy_o,
  output reg         compare_result_flag_o,
  output reg         irq_o
);
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_LOAD  = 3'h1;
  localparam [2:0] S_WAIT  = 3'h2;
  localparam [2:0] S_RUN   = 3'h3;
  localparam [2:0] S_FETCH = 3'h4;
  localparam [2:0] S_FDATA = 3'h5;

  // map pulse level onto the two lines of one axis
  function [1:0] fmt_out;
    input [1:0] fmt;
    input       p;
    input       rev;
    begin
      case (fmt)
        `PT_FMT_CWCCW: fmt_out = {p & ~rev, p & rev};
        `PT_FMT_PD_LO: fmt_out = {p, rev};
        `PT_FMT_PD_HI: fmt_out = {p, ~rev};
        default:       fmt_out = 2'h0;
      endcase
    end
  endfunction

  function [31:0] absv;
    input [31:0] v;
    begin
      absv = v[31] ? (~v + 32'h1) : v;
    end
  endfunction

  // ==========
  // pin synchronisers
  wire [5:0] pin_s;
  pt_sync #(.W(6)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({two_cassettes_i, home_i, start_in_cassette_i,
             start_in_main_i, encoder_in_cassette_i, encoder_in_main_i}),
    .q_o   (pin_s)
  );

  // ==========
  // registers
  reg [`PT_CTRL_W-1:0] ctrl_r;
  reg [31:0]           tgt_r, tgt2_r, init_r, max_r, acc_us_r;
  reg [`PT_TBL_AW-1:0] tbl_wa_r;
  reg [`PT_IRQ_W-1:0]  irq_st_r, irq_en_r;
  reg [31:0]           hsc_r, pos_r;
  wire [1:0] fmt  = ctrl_r[`PT_F_FMT];
  wire [2:0] mode = ctrl_r[`PT_F_MODE];
  wire       src  = ctrl_r[`PT_B_SRC];
  wire wr_cmd = reg_wr_i && (reg_addr_i == `PT_OFF_CMD);
  wire go_cmd   = wr_cmd && reg_wdata_i[`PT_B_GO];
  wire stop_cmd = wr_cmd && reg_wdata_i[`PT_B_STOP];
  wire tbl_we   = reg_wr_i && (reg_addr_i == `PT_OFF_TBL_D);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r   <= {`PT_CTRL_W{1'b0}};
      tgt_r    <= 32'h0;
      tgt2_r   <= 32'h0;
      init_r   <= 32'h0;
      max_r    <= 32'h0;
      acc_us_r <= 32'h0;
      tbl_wa_r <= {`PT_TBL_AW{1'b0}};
      irq_en_r <= {`PT_IRQ_W{1'b0}};
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PT_OFF_CTRL:   ctrl_r   <= reg_wdata_i[`PT_CTRL_W-1:0];
        `PT_OFF_TGT:    tgt_r    <= reg_wdata_i;
        `PT_OFF_TGT2:   tgt2_r   <= reg_wdata_i;
        `PT_OFF_INIT:   init_r   <= reg_wdata_i;
        `PT_OFF_MAX:    max_r    <= reg_wdata_i;
        `PT_OFF_ACC_US: acc_us_r <= reg_wdata_i;
        `PT_OFF_TBL_A:  tbl_wa_r <= reg_wdata_i[`PT_TBL_AW-1:0];
        `PT_OFF_TBL_D:  tbl_wa_r <= tbl_wa_r + 1'b1;
        `PT_OFF_IRQ_EN: irq_en_r <= reg_wdata_i[`PT_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========
  // encoder counter and compare positioning
  reg enc_q_r, start_q_r, cmp_busy_r, run_r, fast_r, cmp_flag_r;
  wire enc_s   = src ? pin_s[1] : pin_s[0];
  wire start_s = src ? pin_s[3] : pin_s[2];
  wire cmp_start = start_s && !start_q_r && !cmp_busy_r;
  reg  cmp_done;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enc_q_r    <= 1'b0;
      start_q_r  <= 1'b0;
      hsc_r      <= 32'h0;
      cmp_busy_r <= 1'b0;
      run_r      <= 1'b0;
      fast_r     <= 1'b0;
      cmp_flag_r <= 1'b0;
      cmp_done   <= 1'b0;
    end else begin
      enc_q_r   <= enc_s;
      start_q_r <= start_s;
      cmp_done  <= 1'b0;
      if (wr_cmd && reg_wdata_i[`PT_B_CLRHSC]) begin
        hsc_r <= 32'h0;
      end else if (enc_s && !enc_q_r) begin
        hsc_r <= hsc_r + 32'h1;
      end
      cmp_flag_r <= (hsc_r >= `PT_CMP_SLOW);
      if (cmp_start) begin
        cmp_busy_r <= 1'b1;
        run_r      <= 1'b1;
        fast_r     <= ctrl_r[`PT_B_TWOSPD];
      end else if (cmp_busy_r) begin
        if (hsc_r >= `PT_CMP_SLOW) begin
          fast_r <= 1'b0;
        end
        if (hsc_r >= `PT_CMP_STOP) begin
          run_r      <= 1'b0;
          fast_r     <= 1'b0;
          cmp_busy_r <= 1'b0;
          cmp_done   <= 1'b1;
        end
      end
    end
  end

  // ==========
  // pulse engine
  reg [2:0]            st_r;
  reg [31:0]           acc_r, spd_r, cnt_r, major_r, n1_r, n2_r;
  reg [31:0]           err1_r, err2_r, wait_r, accp_r, cur_r;
  reg                  lvl_r, en1_r, en2_r, dir1_r, dir2_r, unlim_r;
  reg [`PT_TBL_AW-1:0] tbl_ra_r;
  reg [7:0]            us_r;
  reg [31:0]           rstep_r;
  reg                  mv_done, home_hit;
  wire [31:0] tbl_q;
  wire [32:0] acc_sum = {1'b0, acc_r} + {1'b0, spd_r};
  wire        rise = acc_sum[32] && !lvl_r;
  wire        fall = acc_sum[32] && lvl_r;
  wire [31:0] e1 = err1_r + n1_r;
  wire [31:0] e2 = err2_r + n2_r;
  wire [31:0] delta = (max_r - init_r) >> `PT_RAMP_SHIFT;
  wire [31:0] rstep_lim = acc_us_r >> `PT_RAMP_SHIFT;
  wire        us_tick = (us_r == (`PT_CLK_MHZ - 1));
  wire        ramp_tick = us_tick && (rstep_r >= rstep_lim);
  wire        decel = !unlim_r && ((major_r - cnt_r) <= accp_r);
  wire        pd_fmt = (fmt != `PT_FMT_CWCCW);
  wire        interp = (mode == `PT_M_INTERP);
  wire        jog_end = (mode == `PT_M_JOG) && !ctrl_r[`PT_B_JOGRUN];
  wire        cnt_end = !unlim_r && (cnt_r >= major_r);
  wire [31:0] n1_nxt = absv(cur_r);
  wire [31:0] n2_nxt = interp ? absv(tgt2_r) : 32'h0;

  pt_mem u_mem (
    .clk_i   (clk_i),
    .wr_i    (tbl_we),
    .waddr_i (tbl_wa_r),
    .wdata_i (reg_wdata_i),
    .raddr_i (tbl_ra_r),
    .rdata_o (tbl_q)
  );

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= S_IDLE;
      {acc_r, spd_r, cnt_r, major_r, n1_r, n2_r} <= {6{32'h0}};
      {err1_r, err2_r, wait_r, accp_r, cur_r}    <= {5{32'h0}};
      {lvl_r, en1_r, en2_r, dir1_r, dir2_r, unlim_r} <= 6'h0;
      tbl_ra_r <= {`PT_TBL_AW{1'b0}};
      us_r     <= 8'h0;
      rstep_r  <= 32'h0;
      pos_r    <= 32'h0;
      mv_done  <= 1'b0;
      home_hit <= 1'b0;
    end else begin
      mv_done  <= 1'b0;
      home_hit <= 1'b0;
      us_r <= us_tick ? 8'h0 : us_r + 8'h1;
      if (wr_cmd && reg_wdata_i[`PT_B_CLRPOS]) begin
        pos_r <= 32'h0;
      end else if (st_r == S_RUN && rise && e1 >= major_r) begin
        pos_r <= dir1_r ? pos_r - 32'h1 : pos_r + 32'h1;
      end
      case (st_r)
        S_IDLE: begin
          lvl_r <= 1'b0;
          if (go_cmd) begin
            cur_r    <= tgt_r;
            tbl_ra_r <= {`PT_TBL_AW{1'b0}};
            if (mode == `PT_M_TABLE) begin
              st_r <= S_FETCH;
            end else if (!interp || pin_s[5]) begin
              st_r <= S_LOAD;
            end
          end
        end
        S_FETCH: st_r <= S_FDATA;
        S_FDATA: begin
          if (tbl_q == 32'h0) begin
            st_r    <= S_IDLE;
            mv_done <= 1'b1;
          end else begin
            cur_r    <= tbl_q;
            tbl_ra_r <= tbl_ra_r + 1'b1;
            st_r     <= S_LOAD;
          end
        end
        S_LOAD: begin
          dir1_r  <= (mode == `PT_M_HOME) ? 1'b1 : cur_r[31];
          dir2_r  <= tgt2_r[31];
          n1_r    <= n1_nxt;
          n2_r    <= n2_nxt;
          major_r <= (n2_nxt > n1_nxt) ? n2_nxt : n1_nxt;
          // home and free jog have no end count
          unlim_r <= (mode == `PT_M_HOME) ||
                     ((mode == `PT_M_JOG) && !ctrl_r[`PT_B_JOGTGT]);
          {err1_r, err2_r, cnt_r, accp_r, acc_r} <= {5{32'h0}};
          spd_r   <= (mode == `PT_M_JOG) ? max_r : init_r;
          wait_r  <= 32'h0;
          rstep_r <= 32'h0;
          st_r    <= pd_fmt ? S_WAIT : S_RUN;
        end
        S_WAIT: begin
          wait_r <= wait_r + 32'h1;
          if (wait_r >= DIR_WAIT_CYC - 32'h1) begin
            st_r <= S_RUN;
          end
        end
        S_RUN: begin
          acc_r <= acc_sum[31:0];
          if (acc_sum[32]) begin
            lvl_r <= ~lvl_r;
          end
          if (rise) begin
            cnt_r <= cnt_r + 32'h1;
            // both axes stepped from major count
            en1_r  <= (e1 >= major_r) || unlim_r;
            err1_r <= (e1 >= major_r) ? e1 - major_r : e1;
            en2_r  <= interp && (e2 >= major_r);
            err2_r <= (e2 >= major_r) ? e2 - major_r : e2;
            if (!decel && spd_r < max_r) begin
              accp_r <= accp_r + 32'h1;
            end
          end
          rstep_r <= ramp_tick ? 32'h0 : rstep_r + {31'h0, us_tick};
          if (ramp_tick && (mode != `PT_M_JOG)) begin
            if (decel) begin
              spd_r <= (spd_r - delta < init_r || spd_r < delta) ?
                       init_r : spd_r - delta;
            end else if (spd_r < max_r) begin
              spd_r <= (max_r - spd_r < delta) ? max_r : spd_r + delta;
            end
          end
          if (stop_cmd || (mode == `PT_M_HOME && pin_s[4])) begin
            home_hit <= (mode == `PT_M_HOME) && pin_s[4];
            mv_done  <= 1'b1;
            st_r     <= S_IDLE;
          end else if (jog_end || (fall && cnt_end) ||
                       (cnt_end && !lvl_r) || major_r == 32'h0) begin
            // jog stops on condition or target
            if (mode == `PT_M_TABLE) begin
              st_r <= S_FETCH;
            end else begin
              mv_done <= 1'b1;
              st_r    <= S_IDLE;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ==========
  // interrupts and output flops
  wire [`PT_IRQ_W-1:0] ev = {home_hit, mv_done, cmp_done};
  wire [`PT_IRQ_W-1:0] clr =
    (reg_wr_i && reg_addr_i == `PT_OFF_IRQ_CLR) ?
    reg_wdata_i[`PT_IRQ_W-1:0] : {`PT_IRQ_W{1'b0}};
  wire       mv_busy = (st_r != S_IDLE);
  wire [1:0] ax1 = fmt_out(fmt, lvl_r & en1_r & (st_r == S_RUN), dir1_r);
  wire [1:0] ax2 = fmt_out(fmt, lvl_r & en2_r & (st_r == S_RUN), dir2_r);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_st_r <= {`PT_IRQ_W{1'b0}};
      irq_o    <= 1'b0;
      {pls_a_o, pls_b_o, pls2_a_o, pls2_b_o} <= 4'h0;
      {inverter_run_out_main_o, inverter_fast_out_main_o}         <= 2'h0;
      {inverter_run_out_cassette_o, inverter_fast_out_cassette_o} <= 2'h0;
      counter_ch0_busy_flag_o <= 1'b0;
      counter_ch8_busy_flag_o <= 1'b0;
      pulse_busy_o            <= 1'b0;
      compare_result_flag_o   <= 1'b0;
    end else begin
      // set wins over clear
      irq_st_r <= (irq_st_r & ~clr) | ev;
      irq_o    <= |(irq_st_r & irq_en_r);
      {pls_a_o, pls_b_o}   <= ax1;
      {pls2_a_o, pls2_b_o} <= interp ? ax2 : 2'h0;
      inverter_run_out_main_o      <= run_r & !src;
      inverter_fast_out_main_o     <= fast_r & !src;
      inverter_run_out_cassette_o  <= run_r & src;
      inverter_fast_out_cassette_o <= fast_r & src;
      counter_ch0_busy_flag_o <= (cmp_busy_r & !src) | mv_busy;
      counter_ch8_busy_flag_o <= cmp_busy_r & src;
      pulse_busy_o            <= mv_busy;
      compare_result_flag_o   <= cmp_flag_r;
    end
  end

  // ==========
  // read port, data one cycle after strobe
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `PT_OFF_CTRL:   reg_rdata_o <= {23'h0, ctrl_r};
        `PT_OFF_TGT:    reg_rdata_o <= tgt_r;
        `PT_OFF_TGT2:   reg_rdata_o <= tgt2_r;
        `PT_OFF_INIT:   reg_rdata_o <= init_r;
        `PT_OFF_MAX:    reg_rdata_o <= max_r;
        `PT_OFF_ACC_US: reg_rdata_o <= acc_us_r;
        `PT_OFF_HSC_LO: reg_rdata_o <= {16'h0, hsc_r[15:0]};
        `PT_OFF_HSC_HI: reg_rdata_o <= {16'h0, hsc_r[31:16]};
        `PT_OFF_POS:    reg_rdata_o <= pos_r;
        `PT_OFF_TBL_A:  reg_rdata_o <= {28'h0, tbl_wa_r};
        `PT_OFF_STAT:   reg_rdata_o <= {26'h0, pin_s[5], cmp_flag_r,
                                        dir1_r, cmp_busy_r & src,
                                        cmp_busy_r & !src, mv_busy};
        `PT_OFF_IRQ_ST: reg_rdata_o <= {29'h0, irq_st_r};
        `PT_OFF_IRQ_EN: reg_rdata_o <= {29'h0, irq_en_r};
        default:        reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// file: core/pt_defs.vh
// constants shared by the pulse-train positioning block
// assumes a 250 MHz clock and a register port with 6-bit byte addresses
`ifndef PT_DEFS_VH
`define PT_DEFS_VH
// ==========
// register byte offsets
`define PT_OFF_CTRL    6'h00
`define PT_OFF_CMD     6'h04
`define PT_OFF_TGT     6'h08
`define PT_OFF_TGT2    6'h0c
`define PT_OFF_INIT    6'h10
`define PT_OFF_MAX     6'h14
`define PT_OFF_ACC_US  6'h18
`define PT_OFF_HSC_LO  6'h1c
`define PT_OFF_HSC_HI  6'h20
`define PT_OFF_POS     6'h24
`define PT_OFF_TBL_A   6'h28
`define PT_OFF_TBL_D   6'h2c
`define PT_OFF_STAT    6'h30
`define PT_OFF_IRQ_ST  6'h34
`define PT_OFF_IRQ_EN  6'h38
`define PT_OFF_IRQ_CLR 6'h3c
// ==========
// control fields
`define PT_CTRL_W      9
`define PT_F_FMT       1:0
`define PT_F_MODE      4:2
`define PT_B_SRC       5
`define PT_B_TWOSPD    6
`define PT_B_JOGTGT    7
`define PT_B_JOGRUN    8
`define PT_B_GO        0
`define PT_B_STOP      1
`define PT_B_CLRHSC    2
`define PT_B_CLRPOS    3
// ==========
// output formats and modes
`define PT_FMT_CWCCW   2'h0
`define PT_FMT_PD_LO   2'h1
`define PT_FMT_PD_HI   2'h2
`define PT_M_TRAP      3'h0
`define PT_M_HOME      3'h1
`define PT_M_JOG       3'h2
`define PT_M_TABLE     3'h3
`define PT_M_INTERP    3'h4
// ==========
// compare targets, timing, sizes
`define PT_CMP_SLOW    32'h0000_1194
`define PT_CMP_STOP    32'h0000_1388
`define PT_CLK_MHZ     250
`define PT_DIR_WAIT_US 300
`define PT_RAMP_SHIFT  4
`define PT_TBL_AW      4
`define PT_IRQ_W       3
`endif

// file: core/pt_sync.v
// two-flop synchroniser for pin inputs
// assumes inputs asynchronous to clk_i
`default_nettype none
module pt_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // levels
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_r;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: core/pt_mem.v
// positioning table storage, registered read data
// assumes one writer and one reader on clk_i
`default_nettype none
`include "pt_defs.vh"
module pt_mem (
  // clock
  input  wire                   clk_i,
  // write side
  input  wire                   wr_i,
  input  wire [`PT_TBL_AW-1:0]  waddr_i,
  input  wire [31:0]            wdata_i,
  // read side
  input  wire [`PT_TBL_AW-1:0]  raddr_i,
  output reg  [31:0]            rdata_o
);
  reg [31:0] mem [0:(1<<`PT_TBL_AW)-1];

  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// file: testbench/pt_sva.sv
// assertions on the pulse-train core ports
// assumes bind onto pt_top and a single clock domain
`default_nettype none
`include "pt_defs.vh"
module pt_sva #(
  parameter [31:0] DIR_WAIT_CYC = 32'd75000
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register port
  input wire logic [5:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  // pins and flags
  input wire logic        home_i,
  input wire logic        two_cassettes_i,
  input wire logic        inverter_run_out_main_o,
  input wire logic        inverter_fast_out_main_o,
  input wire logic        inverter_run_out_cassette_o,
  input wire logic        inverter_fast_out_cassette_o,
  input wire logic        pls_a_o,
  input wire logic        pls_b_o,
  input wire logic        counter_ch0_busy_flag_o,
  input wire logic        pulse_busy_o,
  input wire logic        compare_result_flag_o
);
  // ==========
  // control shadow and cycles since move start
  logic [8:0]  ctl_r;
  logic [31:0] wt_r;
  wire         pd = ctl_r[`PT_F_FMT] != `PT_FMT_CWCCW;
  wire  [2:0]  md = ctl_r[`PT_F_MODE];
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_r <= 9'h000;
      wt_r  <= 32'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `PT_OFF_CTRL)
        ctl_r <= reg_wdata_i[8:0];
      if (!pulse_busy_o)
        wt_r <= 32'h0;
      else if (wt_r != 32'hffff_ffff)
        wt_r <= wt_r + 32'h1;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_solo;
    !two_cassettes_i [*4];
  endsequence
  sequence s_go_ip;
    reg_wr_i && reg_addr_i == `PT_OFF_CMD && reg_wdata_i[`PT_B_GO] &&
    md == `PT_M_INTERP && !pulse_busy_o;
  endsequence
  property p_fast_run;
    (!inverter_fast_out_main_o || inverter_run_out_main_o) &&
    (!inverter_fast_out_cassette_o || inverter_run_out_cassette_o);
  endproperty
  a_fast_run: assert property (p_fast_run)
    else $error("fast output without run output");
  property p_fast_off;
    compare_result_flag_o [*4] |->
      !inverter_fast_out_main_o && !inverter_fast_out_cassette_o;
  endproperty
  a_fast_off: assert property (p_fast_off)
    else $error("fast output on past slow point");
  property p_run_busy;
    inverter_run_out_main_o && $past(inverter_run_out_main_o) |->
      counter_ch0_busy_flag_o;
  endproperty
  a_run_busy: assert property (p_run_busy)
    else $error("run output without busy flag");
  property p_move_busy;
    $rose(pulse_busy_o) |-> ##[0:2] counter_ch0_busy_flag_o;
  endproperty
  a_move_busy: assert property (p_move_busy)
    else $error("move without channel busy flag");
  property p_two_pulse;
    !pd && pulse_busy_o && $past(pulse_busy_o) |-> !(pls_a_o && pls_b_o);
  endproperty
  a_two_pulse: assert property (p_two_pulse)
    else $error("forward and reverse pulses together");
  property p_dir_hold;
    pd && pls_a_o |-> $stable(pls_b_o);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction moved during pulse");
  property p_dir_wait;
    pd && $rose(pls_a_o) |-> wt_r >= DIR_WAIT_CYC;
  endproperty
  a_dir_wait: assert property (p_dir_wait)
    else $error("pulse too soon after direction");
  property p_home_end;
    md == `PT_M_HOME && pulse_busy_o && $rose(home_i) |->
      ##[1:12] !pulse_busy_o;
  endproperty
  a_home_end: assert property (p_home_end)
    else $error("home return kept running");
  property p_jog_end;
    md == `PT_M_JOG && $fell(ctl_r[`PT_B_JOGRUN]) |->
      ##[1:16] !pulse_busy_o;
  endproperty
  a_jog_end: assert property (p_jog_end)
    else $error("jog kept running");
  property p_ip_gate;
    s_solo ##0 s_go_ip |=> !pulse_busy_o [*3];
  endproperty
  a_ip_gate: assert property (p_ip_gate)
    else $error("interpolation started with one cassette");
endmodule
bind pt_top pt_sva #(.DIR_WAIT_CYC(DIR_WAIT_CYC)) pt_sva_inst (.*);
`default_nettype wire

// file: testbench/pt_conv_model.sv
// conveyor model: inverter run/fast lines drive an encoder
// assumes one clock; bit 0 main side, bit 1 cassette side
`default_nettype none
module pt_conv_model (
  // clock
  input  wire logic       clk_i,
  // inverter commands
  input  wire logic [1:0] run_i,
  input  wire logic [1:0] fast_i,
  // encoder lines
  output var  logic [1:0] enc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph_r = 1'b0;
  initial enc_o = 2'h0;
  // slow: period 4 cycles, fast: period 2, still while run off
  always @(posedge clk_i) begin
    ph_r <= !ph_r;
    for (int k = 0; k < 2; k++)
      if (run_i[k] && (fast_i[k] || ph_r))
        enc_o[k] <= !enc_o[k];
  end
endmodule
`default_nettype wire

// file: testbench/pulse_train_positioning_bench.sv
// self-checking bench for the pulse-train positioning core
// assumes conveyor model on the encoder pins, short direction wait
`default_nettype none
`include "pt_defs.vh"
module pulse_train_positioning_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [1:0] f;  logic [31:0] t;  logic [3:0] ea, eb;  logic ed;
  } pt_row_t;
  logic clk_i, rst_i, reg_wr_i, reg_rd_i, home_i, two_cassettes_i;
  logic start_in_main_i, start_in_cassette_i, a_q, b_q, c_q, dir;
  logic [5:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, v;
  wire logic encoder_in_main_i, encoder_in_cassette_i;
  logic inverter_run_out_main_o, inverter_fast_out_main_o, pls_a_o;
  logic inverter_run_out_cassette_o, inverter_fast_out_cassette_o;
  logic pls_b_o, pls2_a_o, pls2_b_o, counter_ch0_busy_flag_o, irq_o;
  logic counter_ch8_busy_flag_o, pulse_busy_o, compare_result_flag_o;
  int err_count = 0, cmp_count = 0, na, nb, n2;
  pt_row_t rows [6] = '{
    '{2'h0, 32'h3, 4'h3, 4'h0, 1'h0}, '{2'h0, 32'hffff_fffe, 4'h0, 4'h2, 1'h0},
    '{2'h1, 32'h3, 4'h3, 4'h0, 1'h0}, '{2'h1, 32'hffff_fffe, 4'h2, 4'h0, 1'h1},
    '{2'h2, 32'h3, 4'h3, 4'h0, 1'h1}, '{2'h2, 32'hffff_fffe, 4'h2, 4'h0, 1'h0}};
  pt_top #(.DIR_WAIT_CYC(32'd20)) pt_top_inst (.*);
  pt_conv_model pt_conv_model_inst (.clk_i,
    .run_i({inverter_run_out_cassette_o, inverter_run_out_main_o}),
    .fast_i({inverter_fast_out_cassette_o, inverter_fast_out_main_o}),
    .enc_o({encoder_in_cassette_i, encoder_in_main_i}));
  // ==========
  // pulse counters
  always @(posedge clk_i) begin
    a_q <= pls_a_o;
    b_q <= pls_b_o;
    c_q <= pls2_a_o;
    if (pls_a_o && !a_q) begin
      na++;
      dir <= pls_b_o;
    end
    if (pls_b_o && !b_q) nb++;
    if (pls2_a_o && !c_q) n2++;
  end
  // ==========
  // bus, wait and check tasks
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    d = reg_rdata_o;
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return pulse_busy_o;
      1: return inverter_run_out_main_o;
      2: return inverter_run_out_cassette_o;
      default: return inverter_fast_out_cassette_o;
    endcase
  endfunction
  task automatic wait_on(input int w, input logic lv, input int lim);
    int n;
    for (n = 0; n < lim && sig(w) !== lv; n++)
      @(posedge clk_i);
    if (n == lim) begin
      err_count++;
      $display("mismatch t=%0t wait %0d ran out", $time, w);
      test_done();
    end
  endtask
  task automatic go;
    na = 0;
    nb = 0;
    n2 = 0;
    wr(`PT_OFF_CMD, 32'h1);
  endtask
  task automatic move(input int lim);
    go();
    wait_on(0, 1'b1, 4);
    wait_on(0, 1'b0, lim);
  endtask
  // ==========
  // clock and main sequence
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, home_i, two_cassettes_i} = 5'h10;
    {start_in_main_i, start_in_cassette_i, reg_addr_i} = 8'h00;
    reg_wdata_i = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({inverter_run_out_main_o, pls_a_o, pls_b_o, pulse_busy_o, irq_o,
      counter_ch0_busy_flag_o, compare_result_flag_o} === 7'h0, "reset");
    rd(`PT_OFF_CMD, v);
    chk(v === 32'h0, "command reads zero");
    rd(`PT_OFF_IRQ_CLR, v);
    chk(v === 32'h0, "clear reads zero");
    wr(`PT_OFF_INIT, 32'h4000_0000);
    wr(`PT_OFF_MAX, 32'h4000_0000);
    wr(`PT_OFF_ACC_US, 32'h0);
    foreach (rows[i]) begin
      wr(`PT_OFF_CMD, 32'h8);
      wr(`PT_OFF_CTRL, {30'h0, rows[i].f});
      wr(`PT_OFF_TGT, rows[i].t);
      move(800);
      chk(na == rows[i].ea, "pulse count");
      if (rows[i].f == `PT_FMT_CWCCW)
        chk(nb == rows[i].eb, "reverse count");
      else
        chk(dir === rows[i].ed, "direction level");
      rd(`PT_OFF_POS, v);
      chk(v === rows[i].t, "position");
    end
    $display("test formats done");
    wr(`PT_OFF_CTRL, 32'h0);
    wr(`PT_OFF_CMD, 32'h4);
    start_in_main_i <= 1'b1;
    wait_on(1, 1'b1, 8);
    @(posedge clk_i);
    chk(!inverter_fast_out_main_o && counter_ch0_busy_flag_o, "run on");
    start_in_main_i <= 1'b0;
    wait_on(1, 1'b0, 24000);
    rd(`PT_OFF_HSC_LO, v);
    chk(v >= 32'h1388 && v <= 32'h138b, "run off count");
    rd(`PT_OFF_HSC_HI, v);
    chk(v === 32'h0 && !counter_ch0_busy_flag_o, "count high");
    $display("test single speed done");
    wr(`PT_OFF_CTRL, 32'h60);
    wr(`PT_OFF_CMD, 32'h4);
    start_in_cassette_i <= 1'b1;
    wait_on(2, 1'b1, 8);
    @(posedge clk_i);
    chk(inverter_fast_out_cassette_o && counter_ch8_busy_flag_o, "fast");
    start_in_cassette_i <= 1'b0;
    wait_on(3, 1'b0, 12000);
    rd(`PT_OFF_HSC_LO, v);
    chk(v >= 32'h1194 && v <= 32'h119a, "slow point");
    wait_on(2, 1'b0, 4000);
    rd(`PT_OFF_HSC_LO, v);
    chk(v >= 32'h1388 && v <= 32'h138b, "stop point");
    chk(compare_result_flag_o && !inverter_run_out_cassette_o, "flag");
    $display("test two speed done");
    wr(`PT_OFF_TGT, 32'h4);
    wr(`PT_OFF_CTRL, 32'h108);
    go();
    repeat (100) @(posedge clk_i);
    chk(pulse_busy_o === 1'b1 && na > 8, "jog runs");
    wr(`PT_OFF_CTRL, 32'h008);
    wait_on(0, 1'b0, 16);
    wr(`PT_OFF_CTRL, 32'h188);
    move(400);
    chk(na == 4, "jog target");
    wr(`PT_OFF_CTRL, 32'h4);
    go();
    repeat (60) @(posedge clk_i);
    home_i <= 1'b1;
    wait_on(0, 1'b0, 16);
    chk(na == 0 && nb > 2, "home return");
    home_i <= 1'b0;
    $display("test jog and home done");
    wr(`PT_OFF_TBL_A, 32'h0);
    wr(`PT_OFF_TBL_D, 32'h2);
    wr(`PT_OFF_TBL_D, 32'h3);
    wr(`PT_OFF_TBL_D, 32'h0);
    wr(`PT_OFF_CMD, 32'h8);
    wr(`PT_OFF_IRQ_CLR, 32'h7);
    wr(`PT_OFF_IRQ_EN, 32'h2);
    wr(`PT_OFF_CTRL, 32'hc);
    move(800);
    rd(`PT_OFF_POS, v);
    chk(v === 32'h5 && na == 5 && irq_o, "table moves");
    wr(`PT_OFF_IRQ_EN, 32'h0);
    @(posedge clk_i);
    chk(irq_o === 1'b0, "irq masked");
    wr(`PT_OFF_IRQ_EN, 32'h2);
    wr(`PT_OFF_IRQ_CLR, 32'h2);
    @(posedge clk_i);
    chk(irq_o === 1'b0, "irq cleared");
    $display("test table and irq done");
    wr(`PT_OFF_CTRL, 32'h10);
    wr(`PT_OFF_TGT2, 32'h2);
    go();
    repeat (3) @(posedge clk_i);
    chk(pulse_busy_o === 1'b0, "interp refused");
    two_cassettes_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    move(800);
    chk(na == 4 && n2 == 2, "interp axes");
    wr(`PT_OFF_INIT, 32'h1000_0000);
    wr(`PT_OFF_ACC_US, 32'h10);
    wr(`PT_OFF_CTRL, 32'h0);
    wr(`PT_OFF_TGT, 32'h14);
    move(4000);
    chk(na == 20, "ramp count");
    $display("test interp and ramp done");
    test_done();
  end
endmodule
`default_nettype wire
